// ==== pump_stroke_pkg.sv ====
// Shared constants, register map and types for the stroke mode control
package pump_stroke_pkg;
   // Clock and time base
   localparam int CLK_HZ = 25_000_000;
   localparam int SEC_PER_MIN = 60;
   localparam int MENU_TIMEOUT_S = 60;
   localparam longint MENU_TIMEOUT_CYC = longint'(MENU_TIMEOUT_S) * longint'(CLK_HZ);
   localparam longint STROKE_DEN = longint'(SEC_PER_MIN) * longint'(CLK_HZ);

   // Widths
   localparam int AW = 6;
   localparam int DW = 32;
   localparam int CNT_W = 17;
   localparam int FAC_W = 14;
   localparam int CUR_W = 12;
   localparam int RATE_W = 16;
   localparam int MODE_W = 2;
   localparam int TYPE_W = 3;
   localparam int CMD_W = 6;

   // Register offsets (byte addresses)
   localparam logic [AW-1:0] REG_CTRL = 6'h00;
   localparam logic [AW-1:0] REG_RATE = 6'h04;
   localparam logic [AW-1:0] REG_BATCH = 6'h08;
   localparam logic [AW-1:0] REG_FACTOR = 6'h0C;
   localparam logic [AW-1:0] REG_P1_CUR = 6'h10;
   localparam logic [AW-1:0] REG_P1_RATE = 6'h14;
   localparam logic [AW-1:0] REG_P2_CUR = 6'h18;
   localparam logic [AW-1:0] REG_P2_RATE = 6'h1C;
   localparam logic [AW-1:0] REG_CMD = 6'h20;
   localparam logic [AW-1:0] REG_STATUS = 6'h24;
   localparam logic [AW-1:0] REG_PENDING = 6'h28;
   localparam logic [AW-1:0] REG_EFF_RATE = 6'h2C;

   // Field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_MEM_BIT = 2;
   localparam int CTRL_LOWERR_BIT = 3;
   localparam int CTRL_TYPE_LSB = 4;
   localparam int CMD_STOPSTART = 0;
   localparam int CMD_PAUSE = 1;
   localparam int CMD_CLRCNT = 2;
   localparam int CMD_PUSH = 3;
   localparam int CMD_MENU = 4;
   localparam int CMD_KEY = 5;
   localparam int ST_RUN = 0;
   localparam int ST_PAUSE = 1;
   localparam int ST_FAULT = 2;
   localparam int ST_CURERR = 3;
   localparam int ST_MENU = 4;
   localparam int ST_REJ = 5;

   // Limits; currents are in hundredths of a milliampere, factor in hundredths
   localparam logic [CNT_W-1:0] STROKE_CAP = 17'h1_869F;
   localparam logic [CNT_W-1:0] BATCH_MIN = 17'h0_0001;
   localparam logic [FAC_W-1:0] FAC_MIN = 14'h0001;
   localparam logic [FAC_W-1:0] FAC_MAX = 14'h270F;
   localparam logic [FAC_W-1:0] FAC_UNIT = 14'h0064;
   localparam logic [CUR_W-1:0] CUR_OFFS = 12'h190;
   localparam logic [CUR_W-1:0] CUR_FULL = 12'h7D0;
   localparam logic [CUR_W-1:0] CUR_LOW_ERR = 12'h17C;
   localparam logic [CUR_W-1:0] CUR_MIN_SPAN = 12'h190;

   // Reset values
   localparam logic [RATE_W-1:0] RST_MAX_RATE = 16'h00B4;
   localparam logic [RATE_W-1:0] RST_RATE = 16'h003C;
   localparam logic [CUR_W-1:0] RST_P1_CUR = 12'h190;
   localparam logic [CUR_W-1:0] RST_P2_CUR = 12'h7D0;

   typedef enum logic [MODE_W-1:0] {
      MODE_MANUAL = 2'b00,
      MODE_BATCH = 2'b01,
      MODE_CONTACT = 2'b10,
      MODE_ANALOG = 2'b11
   } mode_t;

   typedef enum logic [TYPE_W-1:0] {
      A_0_20 = 3'b000,
      A_4_20 = 3'b001,
      A_LINEAR = 3'b010,
      A_LOWER = 3'b011,
      A_UPPER = 3'b100
   } atype_t;
endpackage

// ==== edge_sync.sv ====
// Three-stage synchroniser with rising-edge pulse for the external control pin
`timescale 1ns/10ps
`default_nettype none
module edge_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pin_i,
   output logic rise_o
);
   logic s1_q, s2_q, s3_q, level_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
         rise_o <= 1'b0;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // Level only accepted once two later stages agree; one event per rise
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
         rise_o <= (s2_q == s3_q) && s3_q && !level_q;
      end
   end
endmodule
`default_nettype wire

// ==== stroke_timer.sv ====
// Phase accumulator that paces strokes at a rate given in strokes per minute
`timescale 1ns/10ps
`default_nettype none
module stroke_timer #(
   parameter int RATE_W = 16,
   parameter logic [31:0] DEN = 32'h5968_2F00
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic [RATE_W-1:0] rate_i,
   output logic tick_o
);
   logic [31:0] acc_q;
   logic [31:0] sum;

   assign sum = acc_q + 32'(rate_i);

   // Accumulator holds while disabled so a pause does not shorten the next stroke
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_q <= '0;
         tick_o <= 1'b0;
      end else begin
         tick_o <= 1'b0;
         if (en_i) begin
            if (sum >= DEN) begin
               acc_q <= sum - DEN;
               tick_o <= 1'b1;
            end else begin
               acc_q <= sum;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== stroke_mode_ctrl.sv ====
// Stroke generation control: operating modes, stroke memory and menu timeout
//
// What this block does
// - Leave the menu on menu key, or after 60 s without any key.
// - Batch count accepts whole numbers 1 to 99,999 only; others refused.
// - Batch starts on wheel press at push display or external pulse.
// - Memory on: add unexecuted strokes up to 99,999; beyond that, fault.
// - Batch mode: stop/start key or pause clears the stroke memory.
// - Batch and contact keep the stroke rate set in manual mode.
// - Contact mode turns each external pulse into strokes by a factor.
// - Factor is 0.01 to 99.99; strokes = factor x pulses.
// - Fractional remainders add up; reaching 1 gives one extra stroke.
// - Factor 0.75 gives strokes after two, one, one pulses, repeating.
// - Contact, memory off: stop/start, clear counters or pause clears memory.
// - Manual mode runs at the stroke rate set by the operator.
// - Analog mode offers exactly five current processing types.
// - Zero-based range: no strokes at 0 mA, full rate at 20 mA.
// - Offset range: no strokes at 4 mA, full rate at 20 mA.
// - Curve types take rate from a line through two user points.
// - Curve points with currents under 4 mA apart are refused.
// - Low-current option: below 3.8 mA raise error and stop stroking.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module stroke_mode_ctrl import pump_stroke_pkg::*; #(
   parameter logic [RATE_W-1:0] MAX_RATE = RST_MAX_RATE,
   parameter logic [31:0] MENU_TIMEOUT = 32'(MENU_TIMEOUT_CYC)
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // Register port
   input wire logic [AW-1:0] ADDR_I,
   input wire logic [DW-1:0] WR_DATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [DW-1:0] RD_DATA_O,
   // External control pulse and sampled loop current
   input wire logic EXT_PULSE_I,
   input wire logic [CUR_W-1:0] CUR_I,
   // Drive and status
   output logic STROKE_O,
   output logic FAULT_O,
   output logic CUR_ERR_O,
   output logic MENU_ACTIVE_O
);
   mode_t mode_q;
   atype_t atype_q;
   logic mem_en_q, lowerr_en_q, run_q, pause_q, menu_q, rej_q, fault_q, cur_err_q;
   logic [RATE_W-1:0] rate_q, p1_rate_q, p2_rate_q, eff_rate_q, eff_rate_d, a_rate;
   logic [CNT_W-1:0] batch_q, pend_q;
   logic [FAC_W-1:0] factor_q, rem_q;
   logic [CUR_W-1:0] p1_cur_q, p2_cur_q;
   logic [31:0] idle_q;
   logic ext_rise, tick, stroke_ok, idle_done;

   edge_sync u_sync (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .pin_i(EXT_PULSE_I),
      .rise_o(ext_rise)
   );

   stroke_timer #(
      .RATE_W(RATE_W),
      .DEN(32'(STROKE_DEN))
   ) u_timer (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .en_i(stroke_ok),
      .rate_i(eff_rate_q),
      .tick_o(tick)
   );

   // Key commands arrive as write pulses to the command register
   logic wr_cmd, key_stop, key_pause, key_clr, key_push, key_menu, key_any;
   assign wr_cmd = WR_I && (ADDR_I == REG_CMD);
   assign key_stop = wr_cmd && WR_DATA_I[CMD_STOPSTART];
   assign key_pause = wr_cmd && WR_DATA_I[CMD_PAUSE];
   assign key_clr = wr_cmd && WR_DATA_I[CMD_CLRCNT];
   assign key_push = wr_cmd && WR_DATA_I[CMD_PUSH];
   assign key_menu = wr_cmd && WR_DATA_I[CMD_MENU];
   assign key_any = wr_cmd && (WR_DATA_I[CMD_W-1:0] != '0);

   // Write checks
   function automatic logic span_ok(input logic [DW-1:0] a, input logic [CUR_W-1:0] b);
      logic [DW-1:0] d;
      d = (a > 32'(b)) ? (a - 32'(b)) : (32'(b) - a);
      return (a <= 32'(CUR_FULL)) && (d >= 32'(CUR_MIN_SPAN));
   endfunction

   logic type_ok, rate_ok, batch_ok, fac_ok, p1_ok, p2_ok, wr_batch, wr_p1_cur;
   assign type_ok = WR_DATA_I[CTRL_TYPE_LSB +: TYPE_W] <= A_UPPER;
   assign rate_ok = WR_DATA_I <= 32'(MAX_RATE);
   assign batch_ok = (WR_DATA_I >= 32'(BATCH_MIN)) && (WR_DATA_I <= 32'(STROKE_CAP));
   assign fac_ok = (WR_DATA_I >= 32'(FAC_MIN)) && (WR_DATA_I <= 32'(FAC_MAX));
   assign p1_ok = span_ok(WR_DATA_I, p2_cur_q);
   assign p2_ok = span_ok(WR_DATA_I, p1_cur_q);
   assign wr_batch = WR_I && (ADDR_I == REG_BATCH);
   assign wr_p1_cur = WR_I && (ADDR_I == REG_P1_CUR);

   // Settings; a refused write keeps the old value and flags the refusal
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         mode_q <= MODE_MANUAL;
         atype_q <= A_4_20;
         mem_en_q <= 1'b0;
         lowerr_en_q <= 1'b0;
         rate_q <= RST_RATE;
         batch_q <= BATCH_MIN;
         factor_q <= FAC_UNIT;
         p1_cur_q <= RST_P1_CUR;
         p2_cur_q <= RST_P2_CUR;
         p1_rate_q <= '0;
         p2_rate_q <= MAX_RATE;
         rej_q <= 1'b0;
      end else if (WR_I) begin
         unique case (ADDR_I)
            REG_CTRL: begin
               mode_q <= mode_t'(WR_DATA_I[CTRL_MODE_LSB +: MODE_W]);
               mem_en_q <= WR_DATA_I[CTRL_MEM_BIT];
               lowerr_en_q <= WR_DATA_I[CTRL_LOWERR_BIT];
               if (type_ok) begin
                  atype_q <= atype_t'(WR_DATA_I[CTRL_TYPE_LSB +: TYPE_W]);
               end
               rej_q <= !type_ok;
            end
            REG_RATE: begin
               if (rate_ok) begin
                  rate_q <= WR_DATA_I[RATE_W-1:0];
               end
               rej_q <= !rate_ok;
            end
            REG_BATCH: begin
               if (batch_ok) begin
                  batch_q <= WR_DATA_I[CNT_W-1:0];
               end
               rej_q <= !batch_ok;
            end
            REG_FACTOR: begin
               if (fac_ok) begin
                  factor_q <= WR_DATA_I[FAC_W-1:0];
               end
               rej_q <= !fac_ok;
            end
            REG_P1_CUR: begin
               if (p1_ok) begin
                  p1_cur_q <= WR_DATA_I[CUR_W-1:0];
               end
               rej_q <= !p1_ok;
            end
            REG_P2_CUR: begin
               if (p2_ok) begin
                  p2_cur_q <= WR_DATA_I[CUR_W-1:0];
               end
               rej_q <= !p2_ok;
            end
            REG_P1_RATE: begin
               if (rate_ok) begin
                  p1_rate_q <= WR_DATA_I[RATE_W-1:0];
               end
               rej_q <= !rate_ok;
            end
            REG_P2_RATE: begin
               if (rate_ok) begin
                  p2_rate_q <= WR_DATA_I[RATE_W-1:0];
               end
               rej_q <= !rate_ok;
            end
            default: begin
            end
         endcase
      end
   end

   // Contact conversion in hundredths; the remainder carries into the next pulse
   logic [FAC_W:0] csum, cwhole, cfrac;
   assign csum = {1'b0, rem_q} + {1'b0, factor_q};
   assign cwhole = csum / {1'b0, FAC_UNIT};
   assign cfrac = csum % {1'b0, FAC_UNIT};

   // Stroke memory
   logic trig_batch, trig_contact, replace, clr_pend, consume, overflow, pend_mode;
   logic [CNT_W:0] add, base, psum;
   assign pend_mode = (mode_q == MODE_BATCH) || (mode_q == MODE_CONTACT);
   assign trig_batch = (mode_q == MODE_BATCH) && (ext_rise || (key_push && !menu_q));
   assign trig_contact = (mode_q == MODE_CONTACT) && ext_rise;
   assign replace = (trig_batch || trig_contact) && !mem_en_q;
   assign clr_pend = ((mode_q == MODE_BATCH) && (key_stop || key_pause))
      || ((mode_q == MODE_CONTACT) && !mem_en_q && (key_stop || key_pause || key_clr));
   assign consume = tick && pend_mode && (pend_q != '0) && !replace && !clr_pend;

   always_comb begin
      add = '0;
      if (trig_batch) begin
         add = {1'b0, batch_q};
      end else if (trig_contact) begin
         add = {{(CNT_W - FAC_W){1'b0}}, cwhole};
      end
      if (clr_pend || replace) begin
         base = '0;
      end else begin
         base = {1'b0, pend_q} - {{CNT_W{1'b0}}, consume};
      end
      psum = base + add;
   end
   // A new trigger in the clearing cycle is kept: the add follows the clear
   assign overflow = mem_en_q && (psum > {1'b0, STROKE_CAP});

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         pend_q <= '0;
      end else if (overflow) begin
         pend_q <= STROKE_CAP;
      end else begin
         pend_q <= psum[CNT_W-1:0];
      end
   end

   // With 0.75 the remainder walks 75, 50, 25, 0: strokes after 2, 1, 1 pulses
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         rem_q <= '0;
      end else if (trig_contact) begin
         rem_q <= cfrac[FAC_W-1:0];
      end else if (clr_pend && (mode_q == MODE_CONTACT)) begin
         rem_q <= '0;
      end
   end

   // Run, pause and fault; a fault set in the clearing cycle stays set
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         run_q <= 1'b1;
         pause_q <= 1'b0;
         fault_q <= 1'b0;
         cur_err_q <= 1'b0;
      end else begin
         if (key_stop) begin
            run_q <= !run_q;
         end
         if (key_pause) begin
            pause_q <= !pause_q;
         end
         fault_q <= overflow || (fault_q && !key_stop);
         cur_err_q <= lowerr_en_q && (mode_q == MODE_ANALOG) && (CUR_I < CUR_LOW_ERR);
      end
   end

   // Analog mapping; divisor is never zero since curve points stay 4 mA apart
   logic signed [31:0] a_cur, a_i1, a_i2, a_f1, a_f2, a_lo, a_hi, a_num, a_den, a_base, a_val;
   always_comb begin
      a_cur = $signed(32'(CUR_I));
      a_i1 = $signed(32'(p1_cur_q));
      a_i2 = $signed(32'(p2_cur_q));
      a_f1 = $signed(32'(p1_rate_q));
      a_f2 = $signed(32'(p2_rate_q));
      a_lo = (a_i1 < a_i2) ? a_i1 : a_i2;
      a_hi = (a_i1 < a_i2) ? a_i2 : a_i1;
      unique case (atype_q)
         A_0_20: begin
            a_num = a_cur * $signed(32'(MAX_RATE));
            a_den = $signed(32'(CUR_FULL));
            a_base = '0;
         end
         A_4_20: begin
            a_num = (a_cur - $signed(32'(CUR_OFFS))) * $signed(32'(MAX_RATE));
            a_den = $signed(32'(CUR_FULL)) - $signed(32'(CUR_OFFS));
            a_base = '0;
         end
         default: begin
            a_num = (a_cur - a_i1) * (a_f2 - a_f1);
            a_den = a_i2 - a_i1;
            a_base = a_f1;
         end
      endcase
      a_val = a_base + (a_num / a_den);
      // Side bands run the pump only on their own side of the curve points
      if ((atype_q == A_LOWER) && (a_cur > a_hi)) begin
         a_val = '0;
      end
      if ((atype_q == A_UPPER) && (a_cur < a_lo)) begin
         a_val = '0;
      end
      if (a_val < 0) begin
         a_rate = '0;
      end else if (a_val > $signed(32'(MAX_RATE))) begin
         a_rate = MAX_RATE;
      end else begin
         a_rate = a_val[RATE_W-1:0];
      end
   end

   // Only analog overrides the manual rate, so batch and contact inherit it
   assign eff_rate_d = (mode_q == MODE_ANALOG) ? a_rate : rate_q;
   assign stroke_ok = run_q && !pause_q && !fault_q && !cur_err_q;

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         eff_rate_q <= '0;
         STROKE_O <= 1'b0;
      end else begin
         eff_rate_q <= eff_rate_d;
         STROKE_O <= stroke_ok && tick && (pend_mode ? consume : 1'b1);
      end
   end

   // Menu with inactivity timeout
   assign idle_done = idle_q == (MENU_TIMEOUT - 32'd1);
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         menu_q <= 1'b0;
         idle_q <= '0;
      end else begin
         if (key_any) begin
            idle_q <= '0;
         end else if (!idle_done) begin
            idle_q <= idle_q + 32'd1;
         end
         if (key_menu) begin
            menu_q <= !menu_q;
         end else if (menu_q && idle_done) begin
            menu_q <= 1'b0;
         end
      end
   end

   // Register read, data valid in the following cycle only
   logic [DW-1:0] status;
   always_comb begin
      status = '0;
      status[ST_RUN] = run_q;
      status[ST_PAUSE] = pause_q;
      status[ST_FAULT] = fault_q;
      status[ST_CURERR] = cur_err_q;
      status[ST_MENU] = menu_q;
      status[ST_REJ] = rej_q;
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         RD_DATA_O <= '0;
      end else begin
         RD_DATA_O <= '0;
         if (RD_I) begin
            unique case (ADDR_I)
               REG_CTRL: RD_DATA_O <= 32'({atype_q, lowerr_en_q, mem_en_q, mode_q});
               REG_RATE: RD_DATA_O <= 32'(rate_q);
               REG_BATCH: RD_DATA_O <= 32'(batch_q);
               REG_FACTOR: RD_DATA_O <= 32'(factor_q);
               REG_P1_CUR: RD_DATA_O <= 32'(p1_cur_q);
               REG_P1_RATE: RD_DATA_O <= 32'(p1_rate_q);
               REG_P2_CUR: RD_DATA_O <= 32'(p2_cur_q);
               REG_P2_RATE: RD_DATA_O <= 32'(p2_rate_q);
               REG_STATUS: RD_DATA_O <= status;
               REG_PENDING: RD_DATA_O <= 32'(pend_q);
               REG_EFF_RATE: RD_DATA_O <= 32'(eff_rate_q);
               default: RD_DATA_O <= '0;
            endcase
         end
      end
   end

   assign FAULT_O = fault_q;
   assign CUR_ERR_O = cur_err_q;
   assign MENU_ACTIVE_O = menu_q;

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   property p_menu_key_exit;
      menu_q && key_menu |=> !menu_q;
   endproperty
   a_menu_key_exit: assert property (p_menu_key_exit)
      else $error("menu kept open after menu key");

   property p_menu_timeout;
      menu_q && !key_any && idle_done |=> !menu_q;
   endproperty
   a_menu_timeout: assert property (p_menu_timeout)
      else $error("menu not left after idle timeout");

   property p_batch_refuse;
      wr_batch && !batch_ok |=> $stable(batch_q) && rej_q;
   endproperty
   a_batch_refuse: assert property (p_batch_refuse)
      else $error("out of range batch count stored");

   sequence s_batch_fire;
      trig_batch && !mem_en_q;
   endsequence
   property p_batch_fire;
      s_batch_fire |=> pend_q == $past(batch_q);
   endproperty
   a_batch_fire: assert property (p_batch_fire)
      else $error("batch trigger did not load stroke count");

   property p_overflow;
      overflow |=> fault_q && (pend_q == STROKE_CAP) ##1 (fault_q || $past(key_stop));
   endproperty
   a_overflow: assert property (p_overflow)
      else $error("memory overflow did not raise fault");

   property p_batch_clear;
      (mode_q == MODE_BATCH) && (key_stop || key_pause) && !trig_batch |=> pend_q == '0;
   endproperty
   a_batch_clear: assert property (p_batch_clear)
      else $error("stroke memory not cleared");

   sequence s_leave_manual;
      (mode_q == MODE_MANUAL) ##1 ((mode_q == MODE_BATCH) || (mode_q == MODE_CONTACT));
   endsequence
   property p_rate_kept;
      s_leave_manual |=> eff_rate_q == $past(rate_q);
   endproperty
   a_rate_kept: assert property (p_rate_kept)
      else $error("stroke rate changed on leaving manual mode");

   property p_remainder;
      trig_contact |=> (32'(rem_q) + 32'(FAC_UNIT) * 32'($past(cwhole)))
         == (32'($past(rem_q)) + 32'($past(factor_q)));
   endproperty
   a_remainder: assert property (p_remainder)
      else $error("contact remainder lost");

   property p_curve_refuse;
      wr_p1_cur && !p1_ok |=> $stable(p1_cur_q);
   endproperty
   a_curve_refuse: assert property (p_curve_refuse)
      else $error("curve point closer than minimum span stored");

   property p_low_current;
      cur_err_q [*2] |-> !STROKE_O;
   endproperty
   a_low_current: assert property (p_low_current)
      else $error("stroke issued during low current error");
endmodule
`default_nettype wire

// ==== ext_signal_src.sv ====
// External pulse source and loop current source for the stroke control
`timescale 1ns/10ps
`default_nettype none
module ext_signal_src import pump_stroke_pkg::*; (
   // Clock
   input wire logic clk_i,
   // Pin and current
   output logic pulse_o,
   output logic [CUR_W-1:0] cur_o
);
   initial begin
      pulse_o = 1'b0;
      cur_o = CUR_OFFS;
   end
   // High and low long enough for a three-stage synchroniser to see each edge
   task automatic fire(input int n);
      repeat (n) begin
         @(posedge clk_i) pulse_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         pulse_o <= 1'b0;
         repeat (5) @(posedge clk_i);
      end
   endtask
   task automatic set_cur(input logic [CUR_W-1:0] c);
      @(posedge clk_i) cur_o <= c;
   endtask
endmodule
`default_nettype wire

// ==== metering_stroke_mode_control_tb.sv ====
// Self-checking bench for the stroke mode control
`timescale 1ns/10ps
`default_nettype none
module metering_stroke_mode_control_tb import pump_stroke_pkg::*;;
   logic clk, rst, wr, rd, pulse, stroke, fault, cur_err, menu;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata, rdata, v;
   logic [CUR_W-1:0] cur;
   int errors, cmp_count, cyc;
   // Short menu timeout keeps the idle test short; full-scale rate gives a stroke in 23k cycles
   stroke_mode_ctrl #(.MAX_RATE(16'hFFFF), .MENU_TIMEOUT(32'h0000_00C8)) i_stroke_mode_ctrl (
      .CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WR_DATA_I(wdata), .WR_I(wr), .RD_I(rd),
      .RD_DATA_O(rdata), .EXT_PULSE_I(pulse), .CUR_I(cur), .STROKE_O(stroke),
      .FAULT_O(fault), .CUR_ERR_O(cur_err), .MENU_ACTIVE_O(menu));
   ext_signal_src i_ext_signal_src (.clk_i(clk), .pulse_o(pulse), .cur_o(cur));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         test_done;
      end
   end
   task automatic chk(input string n, input logic [DW-1:0] s, input logic [DW-1:0] e);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] e, input string n);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
      chk(n, v, e);
   endtask
   task automatic rej(input logic e);
      rdc(REG_STATUS, (DW'(e) << ST_REJ) | (DW'(1) << ST_RUN), "status");
      chk("refused", v[ST_REJ], e);
   endtask
   task automatic cmd(input logic [DW-1:0] k);
      wr_reg(REG_CMD, k);
      repeat (2) @(posedge clk);
   endtask
   task automatic setc(input logic [CUR_W-1:0] c);
      i_ext_signal_src.set_cur(c);
      repeat (3) @(posedge clk);
   endtask
   task automatic t_regs;
      rdc(REG_RATE, RST_RATE, "rate");
      rdc(6'h30, 32'h0000_0000, "unmapped");
      wr_reg(REG_RATE, 32'h0000_0019);
      rdc(REG_EFF_RATE, 32'h0000_0019, "manual");
      wr_reg(REG_CTRL, 32'h0000_0001);
      rdc(REG_EFF_RATE, 32'h0000_0019, "batch rate");
      wr_reg(REG_CTRL, 32'h0000_0002);
      rdc(REG_EFF_RATE, 32'h0000_0019, "contact rate");
      wr_reg(REG_BATCH, 32'h0000_0000);
      rdc(REG_BATCH, 32'h0000_0001, "batch zero");
      rej(1'b1);
      wr_reg(REG_BATCH, 32'h0001_869F);
      wr_reg(REG_BATCH, 32'h0001_86A0);
      rdc(REG_BATCH, 32'h0001_869F, "batch max");
      $display("done regs");
   endtask
   task automatic t_batch;
      int n;
      wr_reg(REG_RATE, 32'h0000_0000);
      wr_reg(REG_CTRL, 32'h0000_0005);
      cmd(32'h0000_0008);
      rdc(REG_PENDING, 32'h0001_869F, "push");
      i_ext_signal_src.fire(1);
      rdc(REG_PENDING, 32'h0001_869F, "saturate");
      chk("fault", fault, 1'b1);
      cmd(32'h0000_0001);
      rdc(REG_PENDING, 32'h0000_0000, "stop clear");
      cmd(32'h0000_0001);
      wr_reg(REG_BATCH, 32'h0000_0003);
      i_ext_signal_src.fire(1);
      rdc(REG_PENDING, 32'h0000_0003, "pulse batch");
      cmd(32'h0000_0002);
      rdc(REG_PENDING, 32'h0000_0000, "pause clear");
      cmd(32'h0000_0002);
      wr_reg(REG_CTRL, 32'h0000_0001);
      wr_reg(REG_RATE, 32'h0000_FFFF);
      cmd(32'h0000_0008);
      rdc(REG_PENDING, 32'h0000_0003, "push replace");
      n = 0;
      // Sample on the falling edge so the one-cycle stroke pulse is seen while it stands
      while (!stroke && n < 24000) begin
         @(negedge clk);
         n++;
      end
      chk("stroke", stroke, 1'b1);
      rdc(REG_PENDING, 32'h0000_0002, "consume");
      $display("done batch");
   endtask
   task automatic t_contact;
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      wr_reg(REG_RATE, 32'h0000_0000);
      wr_reg(REG_CTRL, 32'h0000_0006);
      wr_reg(REG_FACTOR, 32'h0000_004B);
      for (int k = 0; k < 4; k++) begin
         i_ext_signal_src.fire(1);
         rdc(REG_PENDING, DW'(k), "step down");
      end
      wr_reg(REG_FACTOR, 32'h0000_0096);
      i_ext_signal_src.fire(1);
      rdc(REG_PENDING, 32'h0000_0004, "step up");
      i_ext_signal_src.fire(1);
      rdc(REG_PENDING, 32'h0000_0006, "remainder");
      wr_reg(REG_FACTOR, 32'h0000_2710);
      rdc(REG_FACTOR, 32'h0000_0096, "factor max");
      wr_reg(REG_CTRL, 32'h0000_0002);
      cmd(32'h0000_0004);
      rdc(REG_PENDING, 32'h0000_0000, "clear counters");
      wr_reg(REG_FACTOR, 32'h0000_00FA);
      i_ext_signal_src.fire(2);
      rdc(REG_PENDING, 32'h0000_0003, "replace");
      cmd(32'h0000_0002);
      rdc(REG_PENDING, 32'h0000_0000, "pause clear");
      cmd(32'h0000_0002);
      i_ext_signal_src.fire(1);
      cmd(32'h0000_0001);
      rdc(REG_PENDING, 32'h0000_0000, "stop clear");
      cmd(32'h0000_0001);
      $display("done contact");
   endtask
   task automatic t_analog;
      for (int t = 0; t < 6; t++) begin
         wr_reg(REG_CTRL, DW'(t * 16 + 3));
         rej(t == 5);
      end
      wr_reg(REG_CTRL, 32'h0000_0003);
      setc(12'h000);
      rdc(REG_EFF_RATE, 32'h0000_0000, "0 mA");
      setc(CUR_FULL);
      rdc(REG_EFF_RATE, 32'h0000_FFFF, "20 mA");
      wr_reg(REG_CTRL, 32'h0000_0013);
      setc(CUR_OFFS);
      rdc(REG_EFF_RATE, 32'h0000_0000, "4 mA");
      setc(CUR_FULL);
      rdc(REG_EFF_RATE, 32'h0000_FFFF, "offset 20 mA");
      wr_reg(REG_P1_CUR, 32'h0000_06A4);
      rdc(REG_P1_CUR, 32'h0000_0190, "narrow span");
      wr_reg(REG_P1_RATE, 32'h0000_0014);
      wr_reg(REG_CTRL, 32'h0000_002B);
      setc(12'h4B0);
      rdc(REG_EFF_RATE, 32'h0000_8009, "curve");
      setc(12'h172);
      chk("low current", cur_err, 1'b1);
      setc(CUR_LOW_ERR);
      chk("low edge", cur_err, 1'b0);
      $display("done analog");
   endtask
   task automatic t_menu;
      cmd(32'h0000_0010);
      chk("menu open", menu, 1'b1);
      cmd(32'h0000_0010);
      chk("menu key", menu, 1'b0);
      wr_reg(REG_CMD, 32'h0000_0010);
      repeat (150) @(posedge clk);
      chk("menu held", menu, 1'b1);
      repeat (60) @(posedge clk);
      chk("menu idle", menu, 1'b0);
      $display("done menu");
   endtask
   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = '0;
      wdata = '0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_batch;
      t_contact;
      t_analog;
      t_menu;
      test_done;
   end
endmodule
`default_nettype wire
